// [hw/ppa_top.sv]
// parallel port adapter: two 8-bit ports, four control lines, host register bus
`timescale 1ns/100ps
`include "ppa_params.svh"
`default_nettype none
module ppa_top (
	input  wire logic           CLK_SYS,
	input  wire logic           NRST,
	input  wire logic           CHIP_SEL_HI0,
	input  wire logic           CHIP_SEL_HI1,
	input  wire logic           CHIP_SEL_LO_N,
	input  wire ppa_pkg::ppa_sel_t REG_SEL,
	input  wire logic           RW_DIR,
	input  wire logic           BUS_STROBE,
	input  wire ppa_pkg::ppa_byte_t DATA_IN,
	output var  ppa_pkg::ppa_byte_t DATA_OUT,
	output var  logic           DATA_OE,
	input  wire ppa_pkg::ppa_byte_t PORT_A_IN,
	output var  ppa_pkg::ppa_byte_t PORT_A_OUT,
	output var  ppa_pkg::ppa_byte_t PORT_A_OE,
	input  wire ppa_pkg::ppa_byte_t PORT_B_IN,
	output var  ppa_pkg::ppa_byte_t PORT_B_OUT,
	output var  ppa_pkg::ppa_byte_t PORT_B_OE,
	input  wire logic [1:0]     STROBE_IN,
	input  wire logic [1:0]     CTL_LINE_IN,
	output var  logic [1:0]     CTL_LINE_OUT,
	output var  logic [1:0]     CTL_LINE_OE,
	output var  logic [1:0]     IRQ_OUT,
	output var  logic [1:0]     IRQ_OE
);
	import ppa_pkg::*;

	// one synchroniser for the bus strobe and one for peripheral inputs
	logic [2:0]  strobe_sync_q;
	logic [36:0] per_m_q;
	logic [36:0] per_s_q;
	ppa_phase_e  phase_q;
	logic        strobe_rise;
	logic        strobe_fall;
	logic        selected;
	ppa_byte_t   out_a_q;
	ppa_byte_t   out_b_q;
	ppa_byte_t   dir_a_q;
	ppa_byte_t   dir_b_q;
	logic [5:0]  ctrl_q [2];
	logic [1:0]  flag_stb_q;
	logic [1:0]  flag_ctl_q;
	logic [1:0]  block_q;
	logic [1:0]  arm_stb_q;
	logic [1:0]  arm_ctl_q;
	logic [1:0]  prev_stb_q;
	logic [1:0]  prev_ctl_q;
	logic [1:0]  ctl_level_q;
	logic [1:0]  wr_data_q;
	logic [1:0]  rd_data_q;
	ppa_byte_t   pins_a;
	ppa_byte_t   pins_b;
	logic [1:0]  stb_s;
	logic [1:0]  ctl_s;

	// the bus strobe synchroniser: two flops, plus a third for edge detection
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			strobe_sync_q <= 3'h0;
		end else begin
			strobe_sync_q <= {strobe_sync_q[1:0], BUS_STROBE};
		end
	end

	// peripheral pins resampled so flags and reads never see metastable data
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			per_m_q <= 37'h0;
			per_s_q <= 37'h0;
		end else begin
			per_m_q <= {CTL_LINE_IN, STROBE_IN, PORT_B_IN, PORT_A_IN, 8'h00, 8'h00, 1'b0};
			per_s_q <= per_m_q;
		end
	end

	assign pins_a = per_s_q[24:17];
	assign pins_b = per_s_q[32:25];
	assign stb_s  = per_s_q[34:33];
	assign ctl_s  = per_s_q[36:35];

	// the host holds selects steady over the strobe, so level sampling is safe
	assign strobe_rise = strobe_sync_q[1] & ~strobe_sync_q[2];
	assign strobe_fall = ~strobe_sync_q[1] & strobe_sync_q[2];
	assign selected = CHIP_SEL_HI0 & CHIP_SEL_HI1 & ~CHIP_SEL_LO_N;

	function automatic logic is_data(input ppa_sel_t sel, input logic [1:0] dacc);
		is_data = (sel == `PPA_SEL_DATA_A && dacc[0]) ||
			(sel == `PPA_SEL_DATA_B && dacc[1]);
	endfunction : is_data

	logic [1:0] dacc;
	assign dacc = {ctrl_q[1][`PPA_CB_DIR_ACC], ctrl_q[0][`PPA_CB_DIR_ACC]};

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			phase_q <= PPA_PHASE_IDLE;
		end else if (strobe_rise) begin
			phase_q <= PPA_PHASE_HIGH;
		end else if (strobe_fall) begin
			phase_q <= PPA_PHASE_IDLE;
		end
	end

	// register writes on the falling edge of the strobe
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			out_a_q   <= `PPA_RST_BYTE;
			out_b_q   <= `PPA_RST_BYTE;
			dir_a_q   <= `PPA_RST_BYTE;
			dir_b_q   <= `PPA_RST_BYTE;
			ctrl_q[0] <= `PPA_RST_CTRL;
			ctrl_q[1] <= `PPA_RST_CTRL;
			wr_data_q <= 2'h0;
		end else begin
			wr_data_q <= 2'h0;
			if (strobe_fall && selected && !RW_DIR && phase_q == PPA_PHASE_HIGH) begin
				if (REG_SEL == `PPA_SEL_DATA_A) begin
					if (dacc[0]) begin
						out_a_q <= DATA_IN;
					end else begin
						dir_a_q <= DATA_IN;
					end
				end else if (REG_SEL == `PPA_SEL_CTRL_A) begin
					ctrl_q[0] <= DATA_IN[5:0];
				end else if (REG_SEL == `PPA_SEL_DATA_B) begin
					if (dacc[1]) begin
						out_b_q   <= DATA_IN;
						wr_data_q <= 2'h2;
					end else begin
						dir_b_q <= DATA_IN;
					end
				end else begin
					ctrl_q[1] <= DATA_IN[5:0];
				end
			end
		end
	end

	// data register reads complete at the strobe fall and clear that side's flags
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rd_data_q <= 2'h0;
		end else begin
			rd_data_q <= 2'h0;
			if (strobe_fall && selected && RW_DIR && is_data(REG_SEL, dacc)) begin
				rd_data_q <= (REG_SEL == `PPA_SEL_DATA_A) ? 2'h1 : 2'h2;
			end
		end
	end

	// read path: output driven while selected read strobe is high
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			DATA_OUT <= `PPA_RST_BYTE;
			DATA_OE  <= 1'b0;
		end else begin
			DATA_OE <= strobe_sync_q[1] && selected && RW_DIR;
			if (REG_SEL == `PPA_SEL_DATA_A) begin
				DATA_OUT <= dacc[0] ? pins_a : dir_a_q;
			end else if (REG_SEL == `PPA_SEL_CTRL_A) begin
				DATA_OUT <= {flag_stb_q[0], flag_ctl_q[0], ctrl_q[0]};
			end else if (REG_SEL == `PPA_SEL_DATA_B) begin
				DATA_OUT <= dacc[1] ? ((out_b_q & dir_b_q) | (pins_b & ~dir_b_q)) : dir_b_q;
			end else begin
				DATA_OUT <= {flag_stb_q[1], flag_ctl_q[1], ctrl_q[1]};
			end
		end
	end

	// flag logic per side; a read clear blocks re-setting until a deselected strobe
	for (genvar s = 0; s < 2; s++) begin : g_side
		logic act_stb;
		logic act_ctl;
		logic edge_s;
		logic edge_c;
		assign edge_s = ctrl_q[s][`PPA_CB_EDGE_STB];
		assign edge_c = ctrl_q[s][`PPA_CB_EDGE_CTL];
		assign act_stb = edge_s ? (stb_s[s] & ~prev_stb_q[s]) : (~stb_s[s] & prev_stb_q[s]);
		assign act_ctl = edge_c ? (ctl_s[s] & ~prev_ctl_q[s]) : (~ctl_s[s] & prev_ctl_q[s]);

		always_ff @(posedge CLK_SYS or negedge NRST) begin
			if (!NRST) begin
				prev_stb_q[s] <= 1'b1;
				prev_ctl_q[s] <= 1'b1;
				arm_stb_q[s]  <= 1'b0;
				arm_ctl_q[s]  <= 1'b0;
			end else begin
				prev_stb_q[s] <= stb_s[s];
				prev_ctl_q[s] <= ctl_s[s];
				// inactive level present during a strobe conditions the detector
				if (act_stb) begin
					arm_stb_q[s] <= 1'b0;
				end else if (strobe_rise && (stb_s[s] != edge_s)) begin
					arm_stb_q[s] <= 1'b1;
				end
				if (act_ctl) begin
					arm_ctl_q[s] <= 1'b0;
				end else if (strobe_rise && (ctl_s[s] != edge_c)) begin
					arm_ctl_q[s] <= 1'b1;
				end
			end
		end

		always_ff @(posedge CLK_SYS or negedge NRST) begin
			if (!NRST) begin
				block_q[s] <= 1'b0;
			end else if (rd_data_q[s]) begin
				block_q[s] <= 1'b1;
			end else if (strobe_rise && !selected) begin
				block_q[s] <= 1'b0;
			end
		end

		// a set arriving with a read clear wins
		always_ff @(posedge CLK_SYS or negedge NRST) begin
			if (!NRST) begin
				flag_stb_q[s] <= 1'b0;
				flag_ctl_q[s] <= 1'b0;
			end else begin
				if (act_stb && arm_stb_q[s] && !block_q[s]) begin
					flag_stb_q[s] <= 1'b1;
				end else if (rd_data_q[s]) begin
					flag_stb_q[s] <= 1'b0;
				end
				if (act_ctl && arm_ctl_q[s] && !block_q[s] && !ctrl_q[s][`PPA_CB_CTL_OUT]) begin
					flag_ctl_q[s] <= 1'b1;
				end else if (rd_data_q[s]) begin
					flag_ctl_q[s] <= 1'b0;
				end
			end
		end

		// open drain: only ever pull low; level follows flags so late enable works
		always_ff @(posedge CLK_SYS or negedge NRST) begin
			if (!NRST) begin
				IRQ_OUT[s] <= 1'b0;
				IRQ_OE[s]  <= 1'b0;
			end else begin
				IRQ_OUT[s] <= 1'b0;
				IRQ_OE[s]  <= (flag_stb_q[s] & ctrl_q[s][`PPA_CB_EN_STB]) |
					(flag_ctl_q[s] & ctrl_q[s][`PPA_CB_EN_CTL]);
			end
		end

		// output modes: manual level, or low after data access and set back on deselected strobe (PPA_CB_EN_CTL set) or on the strobe input edge
		always_ff @(posedge CLK_SYS or negedge NRST) begin
			if (!NRST) begin
				ctl_level_q[s] <= 1'b1;
			end else if (ctrl_q[s][`PPA_CB_EDGE_CTL]) begin
				ctl_level_q[s] <= ctrl_q[s][`PPA_CB_EN_CTL];
			end else if ((s == 0 ? rd_data_q[s] : wr_data_q[s]) && ctrl_q[s][`PPA_CB_CTL_OUT]) begin
				ctl_level_q[s] <= 1'b0;
			end else if (ctrl_q[s][`PPA_CB_EN_CTL] && strobe_rise && !selected) begin
				ctl_level_q[s] <= 1'b1;
			end else if (!ctrl_q[s][`PPA_CB_EN_CTL] && act_stb && arm_stb_q[s]) begin
				ctl_level_q[s] <= 1'b1;
			end
		end

		always_ff @(posedge CLK_SYS or negedge NRST) begin
			if (!NRST) begin
				CTL_LINE_OUT[s] <= 1'b0;
				CTL_LINE_OE[s]  <= 1'b0;
			end else begin
				CTL_LINE_OUT[s] <= ctl_level_q[s];
				CTL_LINE_OE[s]  <= ctrl_q[s][`PPA_CB_CTL_OUT];
			end
		end
	end

	// port drivers: direction one drives the output register
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			PORT_A_OUT <= `PPA_RST_BYTE;
			PORT_A_OE  <= `PPA_RST_BYTE;
			PORT_B_OUT <= `PPA_RST_BYTE;
			PORT_B_OE  <= `PPA_RST_BYTE;
		end else begin
			PORT_A_OUT <= out_a_q;
			PORT_A_OE  <= dir_a_q;
			PORT_B_OUT <= out_b_q;
			PORT_B_OE  <= dir_b_q;
		end
	end
endmodule : ppa_top
`default_nettype wire

// [include/ppa_params.svh]
// constants for the parallel port adapter
`ifndef PPA_PARAMS_SVH
`define PPA_PARAMS_SVH
`define PPA_SEL_DATA_A   2'h0
`define PPA_SEL_CTRL_A   2'h1
`define PPA_SEL_DATA_B   2'h2
`define PPA_SEL_CTRL_B   2'h3
`define PPA_CB_EN_STB    0
`define PPA_CB_EDGE_STB  1
`define PPA_CB_DIR_ACC   2
`define PPA_CB_EN_CTL    3
`define PPA_CB_EDGE_CTL  4
`define PPA_CB_CTL_OUT   5
`define PPA_CB_FLAG_CTL  6
`define PPA_CB_FLAG_STB  7
`define PPA_RST_BYTE     8'h00
`define PPA_RST_CTRL     6'h00
`define PPA_MODE_PULSE   2'h1
`define PPA_MODE_MANUAL  2'h2
`endif

// [include/ppa_pkg.sv]
// types shared by the parallel port adapter
package ppa_pkg;
	typedef logic [7:0] ppa_byte_t;
	typedef logic [1:0] ppa_sel_t;
	typedef enum logic [1:0] {
		PPA_PHASE_IDLE = 2'b00,
		PPA_PHASE_HIGH = 2'b01
	} ppa_phase_e;
endpackage : ppa_pkg

// [tb/ppa_top_assertions.sv]
// checker for the parallel port adapter ports
`timescale 1ns/100ps
`default_nettype none
module ppa_top_chk (
	input wire logic               CLK_SYS,
	input wire logic               NRST,
	input wire logic               CHIP_SEL_HI0,
	input wire logic               CHIP_SEL_HI1,
	input wire logic               CHIP_SEL_LO_N,
	input wire logic               RW_DIR,
	input wire logic               BUS_STROBE,
	input wire logic               DATA_OE,
	input wire ppa_pkg::ppa_byte_t PORT_A_OE,
	input wire ppa_pkg::ppa_byte_t PORT_B_OE,
	input wire logic [1:0]         CTL_LINE_OE,
	input wire logic [1:0]         IRQ_OUT,
	input wire logic [1:0]         IRQ_OE
);
	import ppa_pkg::*;
	wire sel = CHIP_SEL_HI0 & CHIP_SEL_HI1 & ~CHIP_SEL_LO_N;
	wire rd_req = sel & RW_DIR & BUS_STROBE;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	AST_OE_CAUSE: assert property (DATA_OE |-> $past(rd_req, 3))
		else $error("data bus driven without a selected read");
	AST_OE_RISE: assert property ($rose(rd_req) |-> ##3 DATA_OE)
		else $error("read data not driven");
	AST_OE_HOLD: assert property ($rose(DATA_OE) |-> DATA_OE [*3])
		else $error("read data dropped early");
	AST_IRQ_LOW: assert property (IRQ_OUT == 2'h0)
		else $error("interrupt pin driven high");
	// two low samples: the first edge of a run may still see power-up values
	AST_RST_OFF: assert property (disable iff (1'b0) (!NRST ##1 !NRST) |->
		{PORT_A_OE, PORT_B_OE, CTL_LINE_OE, IRQ_OE, DATA_OE} == 21'h0)
		else $error("output enabled during reset");
	AST_WR_LANDS: assert property (($changed(PORT_A_OE) || $changed(PORT_B_OE)) |->
		!BUS_STROBE && !$past(RW_DIR, 2) && $past(sel, 2))
		else $error("direction changed outside a write");
	AST_CTL_QUIET: assert property (BUS_STROBE |-> $stable(CTL_LINE_OE))
		else $error("control line mode changed mid strobe");
	AST_IRQ_CLEAR: assert property (($fell(IRQ_OE[0]) || $fell(IRQ_OE[1])) |->
		!BUS_STROBE && $past(sel, 3))
		else $error("interrupt dropped without host access");
	cover property ($rose(IRQ_OE[0]));
	cover property ($rose(IRQ_OE[1]));
	cover property ($rose(DATA_OE));
endmodule : ppa_top_chk
bind ppa_top ppa_top_chk i_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .CHIP_SEL_HI0(CHIP_SEL_HI0),
	.CHIP_SEL_HI1(CHIP_SEL_HI1), .CHIP_SEL_LO_N(CHIP_SEL_LO_N), .RW_DIR(RW_DIR),
	.BUS_STROBE(BUS_STROBE), .DATA_OE(DATA_OE), .PORT_A_OE(PORT_A_OE), .PORT_B_OE(PORT_B_OE),
	.CTL_LINE_OE(CTL_LINE_OE), .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE));
`default_nettype wire

// [tb/ppa_host_bfm.sv]
// host bus model for the parallel port adapter
`timescale 1ns/100ps
`default_nettype none
module ppa_host_bfm (
	input  wire logic               clk,
	input  wire logic               oe,
	input  wire ppa_pkg::ppa_byte_t dout,
	output var  logic               cs_hi0,
	output wire logic               cs_hi1,
	output var  logic               cs_lo_n,
	output var  ppa_pkg::ppa_sel_t  rsel,
	output var  logic               rw,
	output var  logic               stb,
	output var  ppa_pkg::ppa_byte_t din
);
	import ppa_pkg::*;
	logic      valid_addr_flag = 1'b0;
	logic      adr = 1'b1;
	ppa_byte_t rd;
	assign cs_hi1 = valid_addr_flag & adr;
	initial {cs_hi0, cs_lo_n, rsel, rw, stb, din} = '0;
	// dsel 0 selects, 1 to 3 each drop a different select
	task acc(input logic r, input ppa_sel_t s, input ppa_byte_t d, input logic [1:0] dsel);
		@(negedge clk);
		cs_hi0 = dsel != 2'h1;
		cs_lo_n = dsel == 2'h2;
		valid_addr_flag = dsel != 2'h3;
		{rsel, rw} = {s, r};
		din = r ? ~din : d;
		@(negedge clk) stb = 1'b1;
		repeat (5) @(negedge clk);
		rd = oe ? dout : 8'hXX;
		stb = 1'b0;
		// selects outlive the strobe so the trailing edge still sees them
		repeat (5) @(negedge clk);
		valid_addr_flag = 1'b0;
		din = ~din;
	endtask : acc
endmodule : ppa_host_bfm
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the parallel port adapter
`timescale 1ns/100ps
`default_nettype none
module tb;
	import ppa_pkg::*;
	logic       clk_sys = 1'b0;
	logic       nrst = 1'b0;
	logic       cs0, cs1, cs2n, rw, stb, doe;
	ppa_sel_t   rsel;
	ppa_byte_t  din, dout, pa_out, pa_oe, pb_out, pb_oe, ld, drv, da, db, oa, ob;
	logic [1:0] stbi, ctl_drv, ctl_out, ctl_oe, irq_out, irq_oe;
	integer     seed, i, miscompares = 0, compares = 0, cycles = 0;
	// ld models heavy loading: it drags pins low, port A reads see it
	wire ppa_byte_t  pa_in = (pa_out & pa_oe & ~ld) | (drv & ~pa_oe);
	wire ppa_byte_t  pb_in = ((pb_out & pb_oe) | (drv & ~pb_oe)) & ~ld;
	wire logic [1:0] ctl_lv = (ctl_oe & ctl_out) | (~ctl_oe & ctl_drv);
	wire logic [1:0] irq_lv = ~irq_oe;
	wire ppa_byte_t  bus = doe ? dout : din;
	ppa_top i_dut (.CLK_SYS(clk_sys), .NRST(nrst), .CHIP_SEL_HI0(cs0), .CHIP_SEL_HI1(cs1),
		.CHIP_SEL_LO_N(cs2n), .REG_SEL(rsel), .RW_DIR(rw), .BUS_STROBE(stb), .DATA_IN(bus),
		.DATA_OUT(dout), .DATA_OE(doe), .PORT_A_IN(pa_in), .PORT_A_OUT(pa_out), .PORT_A_OE(pa_oe),
		.PORT_B_IN(pb_in), .PORT_B_OUT(pb_out), .PORT_B_OE(pb_oe), .STROBE_IN(stbi),
		.CTL_LINE_IN(ctl_lv), .CTL_LINE_OUT(ctl_out), .CTL_LINE_OE(ctl_oe), .IRQ_OUT(irq_out),
		.IRQ_OE(irq_oe));
	ppa_host_bfm h (.clk(clk_sys), .oe(doe), .dout(bus), .cs_hi0(cs0), .cs_hi1(cs1),
		.cs_lo_n(cs2n), .rsel(rsel), .rw(rw), .stb(stb), .din(din));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input ppa_sel_t s, input ppa_byte_t d);
		h.acc(1'b0, s, d, 2'h0);
	endtask : wr
	task rdc(input ppa_sel_t s, input ppa_byte_t e);
		h.acc(1'b1, s, 8'h00, 2'h0);
		chk({8'h00, h.rd}, {8'h00, e});
	endtask : rdc
	task dsl(input logic [1:0] k);
		h.acc(1'b1, 2'h0, 8'h00, k);
	endtask : dsl
	// settle time so the synchronisers see a level before the next strobe
	task pin(input logic [1:0] s, input logic [1:0] c);
		{stbi, ctl_drv} = {s, c};
		repeat (4) @(negedge clk_sys);
	endtask : pin
	function ppa_byte_t exp_a(input ppa_byte_t o, input ppa_byte_t dr);
		return (o & dr & ~ld) | (drv & ~dr);
	endfunction : exp_a
	function ppa_byte_t exp_b(input ppa_byte_t o, input ppa_byte_t dr);
		return (o & dr) | (drv & ~ld & ~dr);
	endfunction : exp_b
	task print_verdict;
		if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	initial forever #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		seed = 79612;
		{ld, drv, stbi, ctl_drv} = {8'h00, 8'h00, 2'h3, 2'h3};
		repeat (4) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk({pb_oe, pa_oe}, 16'h0000);
		chk({12'h000, ctl_oe, irq_oe}, 16'h0000);
		for (i = 0; i < 4; i++) rdc(i[1:0], 8'h00);
		for (i = 0; i < 6; i++) begin
			{da, db, oa, ob} = $random(seed);
			{ld, drv} = 16'($random(seed));
			if (i == 0) {da, db, ld} = {8'hFF, 8'h00, 8'h0F};
			wr(2'h1, 8'h00);
			wr(2'h3, 8'h00);
			wr(2'h0, da);
			wr(2'h2, db);
			wr(2'h1, 8'h04);
			wr(2'h3, 8'h04);
			wr(2'h0, oa);
			wr(2'h2, ob);
			chk({pb_oe, pa_oe}, {db, da});
			chk({pb_out, pa_out}, {ob, oa});
			rdc(2'h0, exp_a(oa, da));
			rdc(2'h2, exp_b(ob, db));
		end
		wr(2'h1, 8'hFF);
		rdc(2'h1, 8'h3F);
		chk({12'h000, ctl_oe, ctl_lv}, 16'h0007);
		wr(2'h1, 8'h34);
		chk({14'h0000, ctl_lv}, 16'h0002);
		wr(2'h1, 8'h06);
		pin(2'h2, 2'h3);
		dsl(2'h1);
		pin(2'h3, 2'h3);
		dsl(2'h2);
		chk({14'h0000, irq_lv}, 16'h0003);
		rdc(2'h1, 8'h86);
		wr(2'h1, 8'h07);
		chk({14'h0000, irq_lv}, 16'h0002);
		rdc(2'h0, exp_a(oa, da));
		chk({14'h0000, irq_lv}, 16'h0003);
		pin(2'h2, 2'h3);
		rdc(2'h1, 8'h07);
		pin(2'h3, 2'h3);
		rdc(2'h1, 8'h07);
		dsl(2'h3);
		pin(2'h2, 2'h3);
		dsl(2'h1);
		pin(2'h3, 2'h3);
		dsl(2'h2);
		chk({14'h0000, irq_lv}, 16'h0002);
		wr(2'h3, 8'h0C);
		dsl(2'h3);
		pin(2'h3, 2'h1);
		dsl(2'h1);
		chk({14'h0000, irq_lv}, 16'h0000);
		rdc(2'h3, 8'h4C);
		rdc(2'h2, exp_b(ob, db));
		chk({14'h0000, irq_lv}, 16'h0002);
		pin(2'h3, 2'h3);
		// side A control line as output: low after data A read, high on deselected strobe
		wr(2'h1, 8'h2C);
		rdc(2'h0, exp_a(oa, da));
		chk({14'h0000, ctl_lv}, 16'h0002);
		dsl(2'h2);
		chk({14'h0000, ctl_lv}, 16'h0003);
		nrst = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk({12'h000, irq_oe, ctl_oe}, 16'h0000);
		nrst = 1'b1;
		repeat (3) @(negedge clk_sys);
		rdc(2'h1, 8'h00);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
